// *** ecd_pkg.sv ***
// ecd_pkg: constants, types and shared decode for the eight-channel engine
// assumes one clock, a plain register port and one memory bus master port
//
// Behaviour
// - no I/O-to-I/O transfers; other pairings run
// - one I/O acknowledge line per channel
// - router request cleared by acknowledge, per unit
// - memory-to-memory acknowledges only at zero count
// - I/O channel waits in standby between units
// - request bus, run cycles only after grant
// - snoop or non-snoop chosen by bit 11
// - bit 10 yields bus, non-snoop only
// - release bus when nothing is pending
// - hold nonmaskable interrupt while owning bus
// - internal mode: go bit alone requests
// - external mode: router level, pin edge/level
// - dual address only, both addresses driven
// - unit is read to buffer, then write
// - eight channels; go bit puts standby
// - standby request acquires bus; none releases
// - completion or error moves channel to idle
// - only allowed request and endpoint combinations
// - each address increments, decrements or stays
// - counting position at bit 0,4,8,12,16
// - position codes above 100 are prohibited
// - 24-bit count drops by unit size
// - pin sampled each edge; edge is new low
`default_nettype none
package ecd_pkg;
	localparam int NUM_CH = 8;
	localparam int CNT_W = 24;
	// register port layout: channel block = addr[7:5], word = addr[4:2]
	localparam int GLOB_BIT = 8;
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_SRC = 3'h1;
	localparam logic [2:0] REG_DST = 3'h2;
	localparam logic [2:0] REG_CNT = 3'h3;
	localparam logic [2:0] REG_POS = 3'h4;
	localparam logic [8:0] OFS_HOLD = 9'h100;
	localparam logic [8:0] OFS_STATUS = 9'h104;
	// channel_control fields
	localparam int CTL_GO = 0;
	localparam int CTL_EXT = 1;
	localparam int CTL_SIZE = 2;
	localparam int CTL_INTERRUPT_ROUTER = 4;
	localparam int CTL_SRC_IO = 5;
	localparam int CTL_DST_IO = 6;
	localparam int CTL_RELEASE_ON_REQUEST_ENABLE = 10;
	localparam int CTL_SNOOP = 11;
	localparam int CTL_LEV = 12;
	localparam int CTL_SAC = 16;
	localparam int CTL_DAC = 18;
	localparam logic [31:0] CTL_WMASK = 32'h000f_1c7f;
	// status fields
	localparam int STAT_ACT = 0;
	localparam int STAT_DONE = 8;
	localparam int STAT_ERR = 16;
	// values after reset
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] ADDR_RST = 32'h0000_0000;
	localparam logic [23:0] CNT_RST = 24'h00_0000;
	localparam logic [5:0] POS_RST = 6'h00;
	localparam logic [31:0] HOLD_RST = 32'h0000_0000;
	// codes
	localparam logic [1:0] DIR_FIXED = 2'h0;
	localparam logic [1:0] DIR_INC = 2'h1;
	localparam logic [1:0] DIR_DEC = 2'h2;
	localparam logic [1:0] SIZE_32 = 2'h0;
	localparam logic [1:0] SIZE_16 = 2'h1;
	localparam logic [1:0] SIZE_BAD = 2'h3;
	localparam logic [2:0] POS_MAX = 3'h4;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_REQ = 3'b001,
		ST_READ = 3'b011,
		ST_WRITE = 3'b010,
		ST_CHK = 3'b110
	} ecd_state_e;

	// bytes moved per unit
	function automatic logic [23:0] ecd_unit_bytes(input logic [1:0] size);
		if (size == SIZE_32) begin
			return 24'h00_0004;
		end else if (size == SIZE_16) begin
			return 24'h00_0002;
		end
		return 24'h00_0001;
	endfunction

	function automatic logic [7:0] ecd_onehot(input logic [2:0] ch);
		return 8'h01 << ch;
	endfunction

	// configuration that must not start a channel
	function automatic logic ecd_cfg_bad(input logic [31:0] ctl,
		input logic [5:0] pos);
		logic io_any;
		logic pin_mode;
		io_any = ctl[CTL_SRC_IO] | ctl[CTL_DST_IO];
		pin_mode = ctl[CTL_EXT] & ~ctl[CTL_INTERRUPT_ROUTER];
		return (ctl[CTL_SRC_IO] & ctl[CTL_DST_IO]) |
			(pos[2:0] > POS_MAX) | (pos[5:3] > POS_MAX) |
			(ctl[CTL_SIZE+:2] == SIZE_BAD) |
			(ctl[CTL_SAC+:2] == 2'h3) | (ctl[CTL_DAC+:2] == 2'h3) |
			(~ctl[CTL_EXT] & io_any) |
			(pin_mode & ctl[CTL_LEV] & io_any) |
			(pin_mode & ~ctl[CTL_LEV] & ~io_any);
	endfunction
endpackage
`default_nettype wire

// *** ecd_addr_step.sv ***
// ecd_addr_step: next source or destination address after one unit
// assumes direction and position codes were checked before the start
`timescale 1ns/10ps
`default_nettype none
module ecd_addr_step import ecd_pkg::*; (
	// current address and its settings
	input wire logic [31:0] addr_i,
	input wire logic [1:0] dir_i,
	input wire logic [2:0] pos_i,
	input wire logic [1:0] size_i,
	// stepped address
	output logic [31:0] addr_o
);
	logic [31:0] step;
	logic [4:0] shift;

	// bit 0 steps by the unit, higher positions by one at that bit
	assign shift = {pos_i, 2'b00};
	assign step = (pos_i == 3'h0) ? {8'h00, ecd_unit_bytes(size_i)} :
		(32'h0000_0001 << shift);
	assign addr_o = (dir_i == DIR_INC) ? addr_i + step :
		(dir_i == DIR_DEC) ? addr_i - step : addr_i;
endmodule
`default_nettype wire

// *** ecd_dma.sv ***
// ecd_dma: eight-channel dual-address transfer engine with register port
// assumes the core arbiter, the memory bus and the interrupt router run
// on clock_i; only the external request pins are asynchronous
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module ecd_dma import ecd_pkg::*; (
	// clock, reset, enable
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// register port
	input wire logic [8:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// transfer requests and acknowledges
	input wire logic [7:0] interrupt_router_xfer_req_n_i,
	input wire logic [7:0] ext_xfer_req_n_i,
	output logic [7:0] io_ack_n_o,
	output logic [7:0] done_o,
	// bus arbitration toward the core
	output logic nonsnoop_grant_request_o,
	output logic snoop_grant_request_o,
	input wire logic bus_grant_i,
	input wire logic core_release_req_i,
	// memory bus master
	output logic [31:0] mem_addr_o,
	output logic mem_rd_o,
	output logic mem_wr_o,
	output logic [1:0] mem_size_o,
	output logic [31:0] mem_wdata_o,
	input wire logic [31:0] mem_rdata_i,
	input wire logic mem_done_i,
	input wire logic mem_err_i,
	// nonmaskable interrupt pass-through
	input wire logic nonmaskable_irq_i,
	output logic nonmaskable_irq_o
);
	logic rst_meta_reg;
	logic rst_n;
	logic [7:0] ext_meta_reg;
	logic [7:0] ext_sync_reg;
	logic [7:0] ext_prev_reg;
	logic [7:0] ext_fall;
	ecd_state_e state_reg;
	ecd_state_e state_next;
	logic [2:0] cur_reg;
	logic [2:0] cur_next;
	logic [31:0] ctrl_w [NUM_CH];
	logic [31:0] src_w [NUM_CH];
	logic [31:0] dst_w [NUM_CH];
	logic [23:0] cnt_w [NUM_CH];
	logic [5:0] pos_w [NUM_CH];
	logic [7:0] active;
	logic [7:0] done_flag;
	logic [7:0] err_flag;
	logic [7:0] pend;
	logic [7:0] done_pulse;
	logic [2:0] pick_ch;
	logic pick_any;
	logic [31:0] ctl_cur;
	logic [31:0] src_nx;
	logic [31:0] dst_nx;
	logic [23:0] ub_cur;
	logic [23:0] cnt_nx;
	logic cur_io;
	logic unit_ok;
	logic unit_err;
	logic unit_start;
	logic yield;
	logic keep_bus;
	logic ack_cond;
	logic owning;
	logic [31:0] hold_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rd_val;
	logic [31:0] rd_chan;
	logic [2:0] reg_idx;
	logic [2:0] reg_ch;
	logic [7:0] ack_n_reg;
	logic [7:0] done_o_reg;
	logic nsreq_reg;
	logic snoop_grant_request_reg;
	logic [31:0] maddr_reg;
	logic mrd_reg;
	logic mwr_reg;
	logic [1:0] msize_reg;
	logic nmi_hold_reg;
	logic nmi_out_reg;
	logic stat_wr;

	// reset release through two flops
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n <= rst_meta_reg;
		end
	end

	// external pins: two-flop sync, then one more sample for the edge
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			ext_meta_reg <= 8'hff;
			ext_sync_reg <= 8'hff;
			ext_prev_reg <= 8'hff;
		end else if (ce_i) begin
			ext_meta_reg <= ext_xfer_req_n_i;
			ext_sync_reg <= ext_meta_reg;
			ext_prev_reg <= ext_sync_reg;
		end
	end
	assign ext_fall = ext_prev_reg & ~ext_sync_reg;

	// register port decode
	assign reg_idx = reg_addr_i[4:2];
	assign reg_ch = reg_addr_i[7:5];
	assign stat_wr = reg_wr_i && (reg_addr_i == OFS_STATUS);

	// current channel settings and next values after one unit
	assign ctl_cur = ctrl_w[cur_reg];
	assign ub_cur = ecd_unit_bytes(ctl_cur[CTL_SIZE+:2]);
	assign cnt_nx = (cnt_w[cur_reg] > ub_cur) ?
		cnt_w[cur_reg] - ub_cur : 24'h00_0000;
	assign cur_io = ctl_cur[CTL_SRC_IO] | ctl_cur[CTL_DST_IO];
	assign unit_ok = (state_reg == ST_WRITE) && mem_done_i && !mem_err_i;
	assign unit_err = ((state_reg == ST_READ) || (state_reg == ST_WRITE)) &&
		mem_done_i && mem_err_i;
	assign unit_start = (state_next == ST_READ) && (state_reg != ST_READ);

	ecd_addr_step u_src_step (
		.addr_i(src_w[cur_reg]),
		.dir_i(ctl_cur[CTL_SAC+:2]),
		.pos_i(pos_w[cur_reg][2:0]),
		.size_i(ctl_cur[CTL_SIZE+:2]),
		.addr_o(src_nx)
	);

	ecd_addr_step u_dst_step (
		.addr_i(dst_w[cur_reg]),
		.dir_i(ctl_cur[CTL_DAC+:2]),
		.pos_i(pos_w[cur_reg][5:3]),
		.size_i(ctl_cur[CTL_SIZE+:2]),
		.addr_o(dst_nx)
	);

	// per-channel registers, request detection and flags
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		logic [31:0] ctl_r;
		logic [31:0] src_r;
		logic [31:0] dst_r;
		logic [23:0] cnt_r;
		logic [5:0] pos_r;
		logic act_r;
		logic edge_r;
		logic iwait_r;
		logic done_r;
		logic err_r;
		logic wsel;
		logic wr_ctl;
		logic go_w;
		logic bad;
		logic go_ok;
		logic go_zero;
		logic is_cur;
		logic fin;
		logic abort;
		logic req_src;

		assign wsel = reg_wr_i && !reg_addr_i[GLOB_BIT] &&
			(reg_ch == c) && (reg_addr_i[1:0] == 2'b00);
		assign wr_ctl = wsel && (reg_idx == REG_CTRL);
		assign go_w = reg_wdata_i[CTL_GO];
		assign bad = ecd_cfg_bad(reg_wdata_i, pos_r);
		assign go_ok = wr_ctl && go_w && !bad && (cnt_r != CNT_RST);
		assign go_zero = wr_ctl && go_w && !bad && (cnt_r == CNT_RST);
		assign is_cur = (cur_reg == c);
		assign fin = is_cur && unit_ok && (cnt_nx == CNT_RST);
		assign abort = is_cur && unit_err;
		// internal mode is always pending; router by level; pin by mode
		assign req_src = !ctl_r[CTL_EXT] ? 1'b1 :
			ctl_r[CTL_INTERRUPT_ROUTER] ? (!interrupt_router_xfer_req_n_i[c] && !iwait_r) :
			ctl_r[CTL_LEV] ? !ext_sync_reg[c] : edge_r;
		assign pend[c] = act_r && req_src;
		assign active[c] = act_r;
		assign done_flag[c] = done_r;
		assign err_flag[c] = err_r;
		assign done_pulse[c] = fin || abort || go_zero;
		assign ctrl_w[c] = ctl_r;
		assign src_w[c] = src_r;
		assign dst_w[c] = dst_r;
		assign cnt_w[c] = cnt_r;
		assign pos_w[c] = pos_r;

		// software writes first, unit completion overrides
		always_ff @(posedge clock_i or negedge rst_n) begin
			if (!rst_n) begin
				ctl_r <= CTRL_RST;
				src_r <= ADDR_RST;
				dst_r <= ADDR_RST;
				cnt_r <= CNT_RST;
				pos_r <= POS_RST;
			end else if (ce_i) begin
				if (wr_ctl) begin
					ctl_r <= reg_wdata_i & CTL_WMASK;
				end
				if (wsel && (reg_idx == REG_SRC)) begin
					src_r <= reg_wdata_i;
				end
				if (wsel && (reg_idx == REG_DST)) begin
					dst_r <= reg_wdata_i;
				end
				if (wsel && (reg_idx == REG_CNT)) begin
					cnt_r <= reg_wdata_i[CNT_W-1:0];
				end
				if (wsel && (reg_idx == REG_POS)) begin
					pos_r <= reg_wdata_i[5:0];
				end
				if (is_cur && unit_ok) begin
					src_r <= src_nx;
					dst_r <= dst_nx;
					cnt_r <= cnt_nx;
				end
			end
		end

		// channel state flags; hardware set wins over software clear
		always_ff @(posedge clock_i or negedge rst_n) begin
			if (!rst_n) begin
				act_r <= 1'b0;
				edge_r <= 1'b0;
				iwait_r <= 1'b0;
				done_r <= 1'b0;
				err_r <= 1'b0;
			end else if (ce_i) begin
				if (fin || abort || (wr_ctl && (!go_w || bad))) begin
					act_r <= 1'b0;
				end else if (go_ok) begin
					act_r <= 1'b1;
				end
				if (act_r && ext_fall[c]) begin
					edge_r <= 1'b1;
				end else if ((is_cur && unit_start) || !act_r) begin
					edge_r <= 1'b0;
				end
				if (is_cur && unit_ok && cur_io) begin
					iwait_r <= 1'b1;
				end else if (interrupt_router_xfer_req_n_i[c]) begin
					iwait_r <= 1'b0;
				end
				if (done_pulse[c]) begin
					done_r <= 1'b1;
				end else if (stat_wr && reg_wdata_i[STAT_DONE+c]) begin
					done_r <= 1'b0;
				end
				if (abort || (wr_ctl && go_w && bad)) begin
					err_r <= 1'b1;
				end else if (stat_wr && reg_wdata_i[STAT_ERR+c]) begin
					err_r <= 1'b0;
				end
			end
		end
	end

	// fixed priority: lowest channel number first
	always_comb begin
		pick_ch = 3'h0;
		pick_any = 1'b0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (pend[i]) begin
				pick_ch = 3'(i);
				pick_any = 1'b1;
			end
		end
	end

	// bus hand-back between units
	assign yield = core_release_req_i && ctl_cur[CTL_RELEASE_ON_REQUEST_ENABLE] &&
		!ctl_cur[CTL_SNOOP];
	assign keep_bus = pick_any && !yield &&
		(ctrl_w[pick_ch][CTL_SNOOP] == ctl_cur[CTL_SNOOP]);

	// engine sequencing
	always_comb begin
		state_next = state_reg;
		cur_next = cur_reg;
		unique case (state_reg)
			ST_IDLE: begin
				if (pick_any) begin
					state_next = ST_REQ;
					cur_next = pick_ch;
				end
			end
			ST_REQ: begin
				if (bus_grant_i) begin
					state_next = ST_READ;
				end
			end
			ST_READ: begin
				if (mem_done_i) begin
					state_next = mem_err_i ? ST_CHK : ST_WRITE;
				end
			end
			ST_WRITE: begin
				if (mem_done_i) begin
					state_next = ST_CHK;
				end
			end
			ST_CHK: begin
				if (keep_bus) begin
					state_next = ST_READ;
					cur_next = pick_ch;
				end else begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			cur_reg <= 3'h0;
		end else if (ce_i) begin
			state_reg <= state_next;
			cur_reg <= cur_next;
		end
	end

	// acknowledge: I/O access cycles, or the final memory unit
	assign ack_cond = ((state_next == ST_READ) &&
		ctrl_w[cur_next][CTL_SRC_IO]) ||
		((state_next == ST_WRITE) && ctrl_w[cur_next][CTL_DST_IO]) ||
		(unit_ok && !cur_io && (cnt_nx == CNT_RST));

	// data capture and bus outputs, all registered
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			hold_reg <= HOLD_RST;
			ack_n_reg <= 8'hff;
			done_o_reg <= 8'h00;
			nsreq_reg <= 1'b0;
			snoop_grant_request_reg <= 1'b0;
			maddr_reg <= ADDR_RST;
			mrd_reg <= 1'b0;
			mwr_reg <= 1'b0;
			msize_reg <= SIZE_32;
		end else if (ce_i) begin
			if ((state_reg == ST_READ) && mem_done_i && !mem_err_i) begin
				hold_reg <= mem_rdata_i;
			end else if (reg_wr_i && (reg_addr_i == OFS_HOLD)) begin
				hold_reg <= reg_wdata_i;
			end
			ack_n_reg <= ~({8{ack_cond}} & ecd_onehot(cur_next));
			done_o_reg <= done_pulse;
			nsreq_reg <= (state_next != ST_IDLE) &&
				!ctrl_w[cur_next][CTL_SNOOP];
			snoop_grant_request_reg <= (state_next != ST_IDLE) &&
				ctrl_w[cur_next][CTL_SNOOP];
			mrd_reg <= (state_next == ST_READ);
			mwr_reg <= (state_next == ST_WRITE);
			maddr_reg <= (state_next == ST_WRITE) ? dst_w[cur_next] :
				src_w[cur_next];
			msize_reg <= ctrl_w[cur_next][CTL_SIZE+:2];
		end
	end

	// nonmaskable interrupt waits while the engine owns the bus; taken
	// from the next state so the hold lines up with the registered cycles
	assign owning = (state_next != ST_IDLE) && (state_next != ST_REQ);
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			nmi_hold_reg <= 1'b0;
			nmi_out_reg <= 1'b0;
		end else if (ce_i) begin
			if (owning && nonmaskable_irq_i) begin
				nmi_hold_reg <= 1'b1;
			end else if (!owning) begin
				nmi_hold_reg <= 1'b0;
			end
			nmi_out_reg <= !owning &&
				(nonmaskable_irq_i || nmi_hold_reg);
		end
	end

	// read data, one cycle after the strobe
	assign rd_chan = (reg_idx == REG_CTRL) ?
		{ctrl_w[reg_ch][31:1], active[reg_ch]} :
		(reg_idx == REG_SRC) ? src_w[reg_ch] :
		(reg_idx == REG_DST) ? dst_w[reg_ch] :
		(reg_idx == REG_CNT) ? {8'h00, cnt_w[reg_ch]} :
		(reg_idx == REG_POS) ? {26'h000_0000, pos_w[reg_ch]} : 32'h0000_0000;
	assign rd_val = (reg_addr_i[1:0] != 2'b00) ? 32'h0000_0000 :
		!reg_addr_i[GLOB_BIT] ? rd_chan :
		(reg_addr_i == OFS_HOLD) ? hold_reg :
		(reg_addr_i == OFS_STATUS) ? {8'h00, err_flag, done_flag, active} :
		32'h0000_0000;

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= 32'h0000_0000;
		end else if (ce_i) begin
			rdata_reg <= reg_rd_i ? rd_val : 32'h0000_0000;
		end
	end

	assign reg_rdata_o = rdata_reg;
	assign io_ack_n_o = ack_n_reg;
	assign done_o = done_o_reg;
	assign nonsnoop_grant_request_o = nsreq_reg;
	assign snoop_grant_request_o = snoop_grant_request_reg;
	assign mem_addr_o = maddr_reg;
	assign mem_rd_o = mrd_reg;
	assign mem_wr_o = mwr_reg;
	assign mem_size_o = msize_reg;
	assign mem_wdata_o = hold_reg;
	assign nonmaskable_irq_o = nmi_out_reg;
endmodule
`default_nettype wire

// *** ecd_dma_asserts.sv ***
// ecd_dma_asserts: port checker for the eight-channel transfer engine
// assumes one clock domain and the bus model answering on clock_i
`timescale 1ns/10ps
`default_nettype none
module ecd_dma_chk (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// watched ports
	input wire logic [7:0] io_ack_n_o,
	input wire logic [7:0] done_o,
	input wire logic nonsnoop_grant_request_o,
	input wire logic snoop_grant_request_o,
	input wire logic bus_grant_i,
	input wire logic mem_rd_o,
	input wire logic mem_wr_o,
	input wire logic [31:0] mem_wdata_o,
	input wire logic [31:0] mem_rdata_i,
	input wire logic mem_done_i,
	input wire logic mem_err_i,
	input wire logic nonmaskable_irq_o
);
	logic any_req;
	logic busy;
	logic rd_ok;
	// a read that finished without a bus error
	assign rd_ok = mem_rd_o & mem_done_i & ~mem_err_i;
	// either flavour of bus request, and a cycle in flight
	assign any_req = nonsnoop_grant_request_o | snoop_grant_request_o;
	assign busy = mem_rd_o | mem_wr_o;
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);

	rd_wr_excl_a: assert property (!(mem_rd_o && mem_wr_o))
		else $error("read and write at once");
	req_excl_a: assert property (!(nonsnoop_grant_request_o &&
		snoop_grant_request_o))
		else $error("both bus request kinds high");
	grant_owned_a: assert property (busy |-> any_req && bus_grant_i)
		else $error("bus cycle without grant");
	rd_start_a: assert property ($rose(mem_rd_o) |-> $past(bus_grant_i))
		else $error("read began before grant seen");
	wr_after_rd_a: assert property ($rose(mem_wr_o) |->
		$past(mem_rd_o) && $past(mem_done_i))
		else $error("write not preceded by finished read");
	hold_data_a: assert property (rd_ok |=>
		mem_wr_o && mem_wdata_o == $past(mem_rdata_i))
		else $error("held data not written");
	err_stop_a: assert property (mem_done_i && mem_err_i |=>
		!mem_wr_o)
		else $error("write issued after bus error");
	one_ack_a: assert property ($onehot0(~io_ack_n_o))
		else $error("two acknowledges at once");
	mm_ack_a: assert property ((io_ack_n_o != 8'hff) && !busy |->
		$past(mem_wr_o) && $past(mem_done_i))
		else $error("lone acknowledge not after final write");
	nmi_hold_a: assert property (busy |-> !nonmaskable_irq_o)
		else $error("nmi passed while owning bus");
	done_pulse_a: assert property ((done_o != 8'h00) |=>
		(done_o & $past(done_o)) == 8'h00)
		else $error("completion pulse too long");

	// main scenarios reached
	cover property (mem_wr_o && mem_done_i);
	cover property ((io_ack_n_o != 8'hff) && mem_wr_o);
	cover property (snoop_grant_request_o && bus_grant_i);
endmodule
bind ecd_dma ecd_dma_chk chk_u (.clock_i, .rst_n_i, .io_ack_n_o, .done_o,
	.nonsnoop_grant_request_o, .snoop_grant_request_o, .bus_grant_i,
	.mem_rd_o, .mem_wr_o, .mem_wdata_o, .mem_rdata_i, .mem_done_i,
	.mem_err_i, .nonmaskable_irq_o);
`default_nettype wire

// *** ecd_bus_model.sv ***
// ecd_bus_model: core arbiter and memory seen by the transfer engine
// assumes read data are addr xor a fixed pattern; slow_i adds wait states
`timescale 1ns/10ps
`default_nettype none
module ecd_bus_model (
	// clock, reset, pacing
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic slow_i,
	// arbitration
	input wire logic ns_req_i,
	input wire logic s_req_i,
	output logic bus_grant_o,
	// memory bus
	input wire logic [31:0] mem_addr_i,
	input wire logic mem_rd_i,
	input wire logic mem_wr_i,
	input wire logic [31:0] mem_wdata_i,
	output logic [31:0] mem_rdata_o,
	output logic mem_done_o,
	// write log
	output logic [15:0] wr_cnt_o,
	output logic [31:0] last_waddr_o,
	output logic [31:0] last_wdata_o
);
	logic [1:0] wait_reg;
	logic fin;
	// finish once the wait count reaches the chosen latency
	assign fin = (mem_rd_i | mem_wr_i) & ~mem_done_o &
		(wait_reg >= {slow_i, 1'b0});
	// grant follows request; data only valid with done, else toggling
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_grant_o <= 1'b0;
			mem_done_o <= 1'b0;
			mem_rdata_o <= 32'h0000_0000;
			wait_reg <= 2'h0;
			wr_cnt_o <= 16'h0000;
			last_waddr_o <= 32'h0000_0000;
			last_wdata_o <= 32'h0000_0000;
		end else begin
			bus_grant_o <= ns_req_i | s_req_i;
			mem_done_o <= fin;
			wait_reg <= (fin | mem_done_o | ~(mem_rd_i | mem_wr_i)) ?
				2'h0 : wait_reg + 2'h1;
			mem_rdata_o <= (fin & mem_rd_i) ?
				(mem_addr_i ^ 32'hc3c3_0f0f) : ~mem_rdata_o;
			if (fin & mem_wr_i) begin
				wr_cnt_o <= wr_cnt_o + 16'h0001;
				last_waddr_o <= mem_addr_i;
				last_wdata_o <= mem_wdata_i;
			end
		end
	end
endmodule
`default_nettype wire

// *** ecd_dma_tb.sv ***
// ecd_dma_tb: directed scenarios for the eight-channel transfer engine
// assumes the bus model in ecd_bus_model and the bound port checker
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
	error_cnt++; $display("mismatch %s exp %h got %h", n, e, g); end end
module ecd_dma_tb import ecd_pkg::*; ();
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [8:0] reg_addr_i = 9'h000;
	logic [31:0] reg_wdata_i = 32'h0000_0000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic [7:0] interrupt_router_xfer_req_n_i = 8'hff;
	logic [7:0] ext_xfer_req_n_i = 8'hff;
	logic [7:0] io_ack_n_o, done_o, ack_prev;
	logic nonsnoop_grant_request_o, snoop_grant_request_o, bus_grant_i;
	logic [31:0] mem_addr_o, mem_wdata_o, mem_rdata_i, waddr, wdat, rv;
	logic mem_rd_o, mem_wr_o, mem_done_i, nonmaskable_irq_o;
	logic nonmaskable_irq_i = 1'b1;
	logic slow = 1'b0;
	logic rel_req = 1'b0;
	logic berr = 1'b0;
	logic ns_prev;
	logic [1:0] msz;
	int ns_falls = 0;
	logic saw_s = 1'b0;
	logic saw_ns = 1'b0;
	logic [15:0] wr_cnt, w0;
	int ack_falls[8];
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;

	always #2 clock_i = ~clock_i;

	ecd_dma dut_u (.clock_i, .rst_n_i, .ce_i(1'b1), .reg_addr_i,
		.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
		.interrupt_router_xfer_req_n_i, .ext_xfer_req_n_i, .io_ack_n_o, .done_o,
		.nonsnoop_grant_request_o, .snoop_grant_request_o, .bus_grant_i,
		.core_release_req_i(rel_req), .mem_addr_o, .mem_rd_o, .mem_wr_o,
		.mem_size_o(msz), .mem_wdata_o, .mem_rdata_i, .mem_done_i,
		.mem_err_i(berr), .nonmaskable_irq_i, .nonmaskable_irq_o);

	ecd_bus_model bus_u (.clock_i, .rst_n_i, .slow_i(slow),
		.ns_req_i(nonsnoop_grant_request_o), .s_req_i(snoop_grant_request_o),
		.bus_grant_o(bus_grant_i), .mem_addr_i(mem_addr_o),
		.mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o), .mem_wdata_i(mem_wdata_o),
		.mem_rdata_o(mem_rdata_i), .mem_done_o(mem_done_i),
		.wr_cnt_o(wr_cnt), .last_waddr_o(waddr), .last_wdata_o(wdat));

	// acknowledge edges, request kinds seen, hang guard
	always @(posedge clock_i) begin
		ack_prev <= io_ack_n_o;
		for (int i = 0; i < 8; i++) begin
			if (ack_prev[i] === 1'b1 && io_ack_n_o[i] === 1'b0) begin
				ack_falls[i]++;
			end
		end
		saw_s <= saw_s | (snoop_grant_request_o === 1'b1);
		saw_ns <= saw_ns | (nonsnoop_grant_request_o === 1'b1);
		ns_prev <= nonsnoop_grant_request_o;
		if (ns_prev === 1'b1 && !nonsnoop_grant_request_o) begin
			ns_falls++;
		end
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic reg_wr(input logic [8:0] a, input logic [31:0] d);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic reg_rd(input logic [8:0] a, output logic [31:0] d);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
	endtask

	task automatic wait_done(input int ch);
		int n;
		n = 0;
		#1;
		while (done_o[ch] !== 1'b1 && n < 600) begin
			@(posedge clock_i);
			#1 n++;
		end
		`CHK("done", 1'b1, done_o[ch])
	endtask

	// addresses, count, positions, then control with go
	task automatic cfg(input int ch, input logic [31:0] ctl,
		input logic [5:0] pos, input logic [31:0] s, d, input logic [23:0] c);
		logic [8:0] b;
		b = 9'(ch * 32);
		reg_wr(b + 9'h04, s);
		reg_wr(b + 9'h08, d);
		reg_wr(b + 9'h0c, {8'h00, c});
		reg_wr(b + 9'h10, {26'h0, pos});
		reg_wr(b, ctl);
	endtask

	// memory-to-memory run on a single go write
	task automatic mm_run(input int ch, input logic [31:0] ctl,
		input logic [5:0] pos, input logic [31:0] s, d, input logic [23:0] c,
		input logic [31:0] ea, es);
		cfg(ch, ctl, pos, s, d, c);
		wait_done(ch);
		`CHK("dst", ea, waddr)
		`CHK("data", es ^ 32'hc3c3_0f0f, wdat)
		`CHK("size", ctl[3:2], msz)
		reg_rd(9'(ch * 32 + 12), rv);
		`CHK("count", 32'h0, rv)
		reg_rd(9'(ch * 32), rv);
		`CHK("go", 1'b0, rv[0])
		`CHK("acks", 1, ack_falls[ch])
	endtask

	// a refused setup flags an error and never runs
	task automatic bad_cfg(input logic [31:0] ctl, input logic [5:0] pos);
		cfg(4, ctl, pos, 32'h7000, 32'h7100, 24'h4);
		repeat (4) @(posedge clock_i);
		reg_rd(OFS_STATUS, rv);
		`CHK("err", 2'b10, {rv[STAT_ERR+4], rv[STAT_ACT+4]})
		reg_wr(OFS_STATUS, 32'h0010_0010);
	endtask

	// a bus error aborts the channel: error flag, done pulse, no write
	task automatic bus_err();
		berr <= 1'b1;
		w0 = wr_cnt;
		cfg(5, 32'h0000_0001, 6'h00, 32'h8000, 32'h8100, 24'h8);
		wait_done(5);
		berr <= 1'b0;
		`CHK("no write", w0, wr_cnt)
		reg_rd(OFS_STATUS, rv);
		`CHK("abort", 2'b10, {rv[STAT_ERR+5], rv[STAT_ACT+5]})
		reg_wr(OFS_STATUS, 32'h0020_2000);
	endtask

	// router request: one unit per request, standby between units
	task automatic router_io();
		int n;
		cfg(2, 32'h0001_0053, 6'h00, 32'h3000, 32'h4000, 24'h8);
		w0 = wr_cnt;
		interrupt_router_xfer_req_n_i[2] <= 1'b0;
		for (n = 0; n < 600 && ack_falls[2] == 0; n++) @(posedge clock_i);
		interrupt_router_xfer_req_n_i[2] <= 1'b1;
		repeat (10) @(posedge clock_i);
		`CHK("one unit", w0 + 16'h1, wr_cnt)
		reg_rd(OFS_STATUS, rv);
		`CHK("standby", 1'b1, rv[STAT_ACT+2])
		interrupt_router_xfer_req_n_i[2] <= 1'b0;
		wait_done(2);
		interrupt_router_xfer_req_n_i[2] <= 1'b1;
		`CHK("io dst", 32'h4000, waddr)
		`CHK("io data", 32'h3004 ^ 32'hc3c3_0f0f, wdat)
		`CHK("io acks", 2, ack_falls[2])
	endtask

	// pin falling edge starts an I/O source unit
	task automatic pin_edge();
		cfg(3, 32'h0004_0023, 6'h00, 32'h5000, 32'h6000, 24'h4);
		w0 = wr_cnt;
		repeat (10) @(posedge clock_i);
		`CHK("no pin", w0, wr_cnt)
		ext_xfer_req_n_i[3] <= 1'b0;
		wait_done(3);
		`CHK("pin dst", 32'h6000, waddr)
		`CHK("pin data", 32'h5000 ^ 32'hc3c3_0f0f, wdat)
		ext_xfer_req_n_i[3] <= 1'b1;
	endtask

	initial begin
		repeat (8) @(posedge clock_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		reg_rd(9'h0a4, rv);
		`CHK("src rst", ADDR_RST, rv)
		reg_rd(9'h1fc, rv);
		`CHK("unmapped", 32'h0, rv)
		mm_run(0, 32'h0005_0801, 6'h08, 32'h1000, 32'h2000, 24'hc,
			32'h2020, 32'h1008);
		`CHK("snoop", 1'b1, saw_s)
		slow <= 1'b1;
		rel_req <= 1'b1;
		mm_run(1, 32'h000a_0405, 6'h02, 32'ha000_1000, 32'hb000_0000,
			24'h6, 32'hafff_fffc, 32'ha000_0e00);
		slow <= 1'b0;
		rel_req <= 1'b0;
		`CHK("nonsnoop", 1'b1, saw_ns)
		`CHK("yield", 3, ns_falls)
		bad_cfg(32'h0000_0073, 6'h00);
		bad_cfg(32'h0000_0001, 6'h05);
		bad_cfg(32'h0000_0021, 6'h00);
		bad_cfg(32'h0000_0001, 6'h28);
		bus_err();
		router_io();
		pin_edge();
		repeat (4) @(posedge clock_i);
		`CHK("bus free", 1'b0, nonsnoop_grant_request_o)
		`CHK("nmi", 1'b1, nonmaskable_irq_o)
		wrap_up();
	end
endmodule
`default_nettype wire
